// File: hdl/fieldbus_drive_register_gateway.sv
// Notes on behaviour
// - Fetched register content readable as read result.
// - Drive write response readable as write response.
// - Save to volatile commit activates in RAM.
// - Save to persistent commit also stores permanently.
// - One commit activates all earlier writes except input writes still awaiting the next tick.
// - Commit need depends on drive setting.
// - Wide input: two entries, value, two links.
// - Narrow inputs: value forwarded to linked register.
// - Link and filter writable only when pre-operational.
// - Raw status read-only, refreshed every 2 ms.
// - Filtered status: four entries, fixed source, filter.
// - Inputs processed on fixed 2 ms cycle.
`timescale 1ns/1ns
module fieldbus_drive_register_gateway #(
    parameter int unsigned CYCLE_CLKS = gateway_pkg::CYCLE_CLKS
) (
    input wire logic i_clk_sys,               // System clock, 10 MHz.
    input wire logic i_resetn,                // Synchronous reset, active low.
    input wire logic i_od_wr,                 // Object write strobe.
    input wire logic i_od_rd,                 // Object read strobe.
    input wire logic [15:0] i_od_index,       // Object index.
    input wire logic [7:0] i_od_sub,          // Object subindex.
    input wire logic [31:0] i_od_wdata,       // Object write value.
    output logic o_od_ack,                    // Access answered.
    output logic o_od_err,                    // Access refused.
    output logic [31:0] o_od_rdata,           // Object read value.
    input wire logic i_node_preop,            // Node is pre-operational.
    input wire logic i_drive_running,         // Drive is running.
    input wire logic i_commit_required,       // commit_behaviour_setting: commit needed.
    output logic o_drv_req,                   // Drive transaction request.
    output logic [1:0] o_drv_op,              // Drive transaction code.
    output logic [15:0] o_drv_addr,           // Drive register address.
    output logic [15:0] o_drv_wdata,          // Drive register write data.
    input wire logic i_drv_done,              // Drive transaction complete.
    input wire logic [15:0] i_drv_rdata,      // Drive read data or response.
    input wire logic [15:0] i_drv_status,     // Live drive status word.
    output logic [15:0] o_status_raw,         // Unfiltered status copy.
    output logic [15:0] o_status_filt,        // Filtered status copy.
    output logic o_param_unapplied            // Written parameters await commit.
);

    // =====================================================================
    // Cycle tick
    // =====================================================================
    logic tick;

    cycle_timer #(.PERIOD(CYCLE_CLKS)) u_cycle_timer (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .o_tick(tick)
    );

    // =====================================================================
    // Object access decode
    // =====================================================================
    localparam int NC = gateway_pkg::NARROW_COUNT;
    localparam int NS = gateway_pkg::CFG_SLOTS;

    logic [31:0] rd_req_q, wr_req_q, commit_ram_q, commit_nv_q;
    logic [31:0] wide_val_q, wide_link_q;
    logic [15:0] nar_val_q [NC];
    logic [15:0] nar_link_q [NC];
    logic [15:0] filt_val_q, filt_type_q, rd_result_q, wr_resp_q;

    wire cfg_open = i_node_preop & ~i_drive_running;
    wire sub_cnt = i_od_sub == gateway_pkg::SUB_COUNT;
    wire sub_val = i_od_sub == gateway_pkg::SUB_VALUE;
    wire sub_lnk = i_od_sub == gateway_pkg::SUB_LINK;
    wire sub_fv = i_od_sub == gateway_pkg::SUB_FILT_VAL;
    wire sub_ft = i_od_sub == gateway_pkg::SUB_FILT_TYPE;
    wire is_rdreq = i_od_index == gateway_pkg::IDX_RD_REQ;
    wire is_wrreq = i_od_index == gateway_pkg::IDX_WR_REQ;
    wire is_cram = i_od_index == gateway_pkg::IDX_COMMIT_RAM;
    wire is_cnv = i_od_index == gateway_pkg::IDX_COMMIT_NV;
    wire is_wide = i_od_index == gateway_pkg::IDX_CFG_WIDE;
    wire is_raw = i_od_index == gateway_pkg::IDX_STAT_RAW;
    wire is_filt = i_od_index == gateway_pkg::IDX_STAT_FILT;
    wire is_rres = i_od_index == gateway_pkg::IDX_RD_RESULT;
    wire is_wres = i_od_index == gateway_pkg::IDX_WR_RESP;
    wire is_save = i_od_wdata == gateway_pkg::SAVE_WORD;

    wire w_rdreq = i_od_wr & is_rdreq & sub_val;
    wire w_wrreq = i_od_wr & is_wrreq & sub_val;
    wire w_cram = i_od_wr & is_cram & sub_cnt;
    wire w_cnv = i_od_wr & is_cnv & sub_cnt;
    wire w_wval = i_od_wr & is_wide & sub_val;
    wire w_wlnk = i_od_wr & is_wide & sub_lnk & cfg_open;
    wire w_fval = i_od_wr & is_filt & sub_fv & cfg_open;
    wire w_ftyp = i_od_wr & is_filt & sub_ft & cfg_open;

    logic [NC-1:0] nar_hit, w_nval, w_nlnk;
    logic [NS-1:0] slot_valid, slot_write;
    logic [15:0] slot_addr [NS];
    logic [15:0] slot_data [NS];

    // Slots 0 and 1 are the two halves of the wide object.
    assign slot_addr[0] = wide_link_q[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
    assign slot_addr[1] = wide_link_q[gateway_pkg::ADDR_MSB:gateway_pkg::ADDR_LSB];
    assign slot_data[0] = wide_val_q[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
    assign slot_data[1] = wide_val_q[gateway_pkg::ADDR_MSB:gateway_pkg::ADDR_LSB];
    assign slot_write[0] = w_wval;
    assign slot_write[1] = w_wval;

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_narrow
            assign nar_hit[g] = i_od_index == gateway_pkg::IDX_CFG_NARROW[g];
            assign w_nval[g] = i_od_wr & nar_hit[g] & sub_val;
            assign w_nlnk[g] = i_od_wr & nar_hit[g] & sub_lnk & cfg_open;
            assign slot_addr[g+2] = nar_link_q[g];
            assign slot_data[g+2] = nar_val_q[g];
            assign slot_write[g+2] = w_nval[g];
            always_ff @(posedge i_clk_sys) begin
                if (!i_resetn) begin
                    nar_val_q[g] <= '0;
                    nar_link_q[g] <= gateway_pkg::LINK_NONE;
                end else begin
                    if (w_nval[g]) begin
                        nar_val_q[g] <= i_od_wdata[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
                    end
                    if (w_nlnk[g]) begin
                        nar_link_q[g] <= i_od_wdata[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
                    end
                end
            end
        end
        for (g = 0; g < NS; g++) begin : g_slot
            assign slot_valid[g] = slot_addr[g] != gateway_pkg::LINK_NONE;
        end
    endgenerate

    // Narrow object read selection.
    logic [31:0] nar_rdata;
    logic nar_rok;
    always_comb begin
        nar_rdata = '0;
        nar_rok = 1'b0;
        for (int i = 0; i < NC; i++) begin
            if (nar_hit[i]) begin
                nar_rok = sub_cnt | sub_val | sub_lnk;
                nar_rdata = sub_cnt ? gateway_pkg::CFG_ENTRIES :
                            sub_val ? {16'h0000, nar_val_q[i]} : {16'h0000, nar_link_q[i]};
            end
        end
    end

    wire w_ok = w_rdreq | w_wrreq | w_cram | w_cnv | w_wval | w_wlnk | w_fval | w_ftyp
              | (|w_nval) | (|w_nlnk);
    wire req_obj = is_rdreq | is_wrreq;
    wire r_ok = (req_obj & (sub_cnt | sub_val)) | ((is_cram | is_cnv) & sub_cnt)
              | (is_wide & (sub_cnt | sub_val | sub_lnk)) | ((is_raw | is_rres | is_wres) & sub_cnt)
              | (is_filt & (sub_cnt | sub_val | sub_lnk | sub_fv | sub_ft)) | nar_rok;
    wire [31:0] filt_rdata = sub_cnt ? gateway_pkg::FILT_ENTRIES :
                             sub_val ? {16'h0000, o_status_filt} :
                             sub_lnk ? {16'h0000, gateway_pkg::FILT_SRC_ADDR} :
                             sub_fv ? {16'h0000, filt_val_q} : {16'h0000, filt_type_q};
    wire [31:0] rdata_d = (req_obj & sub_cnt) ? gateway_pkg::REQ_ENTRIES :
                          is_rdreq ? rd_req_q : is_wrreq ? wr_req_q :
                          is_cram ? commit_ram_q : is_cnv ? commit_nv_q :
                          is_wide ? (sub_cnt ? gateway_pkg::CFG_ENTRIES :
                                     sub_val ? wide_val_q : wide_link_q) :
                          is_raw ? {16'h0000, o_status_raw} :
                          is_filt ? filt_rdata :
                          is_rres ? {16'h0000, rd_result_q} :
                          is_wres ? {16'h0000, wr_resp_q} : nar_rdata;

    // =====================================================================
    // Object storage and access answer
    // =====================================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rd_req_q <= '0;
            wr_req_q <= '0;
            commit_ram_q <= '0;
            commit_nv_q <= '0;
            wide_val_q <= '0;
            wide_link_q <= {gateway_pkg::LINK_NONE, gateway_pkg::LINK_NONE};
            filt_val_q <= gateway_pkg::FILT_VAL_RESET;
            filt_type_q <= gateway_pkg::FILT_TYPE_BITMASK;
            o_od_ack <= 1'b0;
            o_od_err <= 1'b0;
            o_od_rdata <= '0;
        end else begin
            if (w_rdreq) rd_req_q <= i_od_wdata;
            if (w_wrreq) wr_req_q <= i_od_wdata;
            if (w_cram) commit_ram_q <= i_od_wdata;
            if (w_cnv) commit_nv_q <= i_od_wdata;
            if (w_wval) wide_val_q <= i_od_wdata;
            if (w_wlnk) wide_link_q <= i_od_wdata;
            if (w_fval) filt_val_q <= i_od_wdata[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
            if (w_ftyp) filt_type_q <= i_od_wdata[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB];
            o_od_ack <= i_od_wr | i_od_rd;
            o_od_err <= (i_od_wr & ~w_ok) | (~i_od_wr & i_od_rd & ~r_ok);
            o_od_rdata <= (~i_od_wr & i_od_rd & r_ok) ? rdata_d : '0;
        end
    end

    // =====================================================================
    // Status copies
    // =====================================================================
    wire [15:0] diff = (i_drv_status >= o_status_filt) ? (i_drv_status - o_status_filt)
                                                       : (o_status_filt - i_drv_status);
    wire bit_change = |((i_drv_status ^ o_status_filt) & ~filt_val_q);
    wire passes = (filt_type_q == gateway_pkg::FILT_TYPE_ANALOG) ? (diff > filt_val_q)
                                                                 : bit_change;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_status_raw <= gateway_pkg::STATUS_RESET;
            o_status_filt <= gateway_pkg::STATUS_RESET;
        end else if (tick) begin
            o_status_raw <= i_drv_status;
            if (passes) o_status_filt <= i_drv_status;
        end
    end

    // =====================================================================
    // Pending work and drive transactions
    // =====================================================================
    gateway_pkg::xact_state_t state_q;
    gateway_pkg::drive_op_t cur_op_q;
    logic cur_host_q, rd_pend_q, wr_pend_q, cram_pend_q, cnv_pend_q;
    logic [NS-1:0] dirty_q, due_q;

    // Lowest ready slot with a valid link.
    logic [NS-1:0] live, pick;
    logic [15:0] pick_addr, pick_data;
    always_comb begin
        live = due_q & slot_valid;
        pick = '0;
        pick_addr = '0;
        pick_data = '0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (live[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                pick_addr = slot_addr[i];
                pick_data = slot_data[i];
            end
        end
    end

    wire idle = state_q == gateway_pkg::ST_IDLE;
    wire done = (state_q == gateway_pkg::ST_BUSY) & i_drv_done;
    wire go_rd = idle & rd_pend_q;
    wire go_wr = idle & ~rd_pend_q & wr_pend_q;
    wire go_cfg = idle & ~rd_pend_q & ~wr_pend_q & (|live);
    // Commits wait for pending host requests and due input slots, not for dirty slots still awaiting the tick.
    wire go_cram = idle & ~rd_pend_q & ~wr_pend_q & ~(|live) & cram_pend_q;
    wire go_cnv = idle & ~rd_pend_q & ~wr_pend_q & ~(|live) & ~cram_pend_q
                & cnv_pend_q;
    wire go = go_rd | go_wr | go_cfg | go_cram | go_cnv;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            cram_pend_q <= 1'b0;
            cnv_pend_q <= 1'b0;
            dirty_q <= '0;
            due_q <= '0;
        end else begin
            rd_pend_q <= w_rdreq | (rd_pend_q & ~go_rd);
            wr_pend_q <= w_wrreq | (wr_pend_q & ~go_wr);
            cram_pend_q <= (w_cram & is_save) | (cram_pend_q & ~go_cram);
            cnv_pend_q <= (w_cnv & is_save) | (cnv_pend_q & ~go_cnv);
            dirty_q <= slot_write | (dirty_q & ~{NS{tick}});
            due_q <= (tick ? dirty_q : '0) | (due_q & slot_valid & ~(go_cfg ? pick : '0));
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            state_q <= gateway_pkg::ST_IDLE;
            cur_op_q <= gateway_pkg::OP_READ;
            cur_host_q <= 1'b0;
            o_drv_req <= 1'b0;
            o_drv_op <= gateway_pkg::OP_READ;
            o_drv_addr <= '0;
            o_drv_wdata <= '0;
            rd_result_q <= '0;
            wr_resp_q <= '0;
            o_param_unapplied <= 1'b0;
        end else begin
            case (state_q)
                gateway_pkg::ST_IDLE: begin
                    if (go) begin
                        state_q <= gateway_pkg::ST_BUSY;
                        o_drv_req <= 1'b1;
                        cur_host_q <= go_rd | go_wr;
                        cur_op_q <= go_rd ? gateway_pkg::OP_READ :
                                    go_cram ? gateway_pkg::OP_COMMIT_RAM :
                                    go_cnv ? gateway_pkg::OP_COMMIT_NV : gateway_pkg::OP_WRITE;
                        o_drv_op <= go_rd ? gateway_pkg::OP_READ :
                                    go_cram ? gateway_pkg::OP_COMMIT_RAM :
                                    go_cnv ? gateway_pkg::OP_COMMIT_NV : gateway_pkg::OP_WRITE;
                        o_drv_addr <= go_rd ? rd_req_q[gateway_pkg::ADDR_MSB:gateway_pkg::ADDR_LSB] :
                                      go_wr ? wr_req_q[gateway_pkg::ADDR_MSB:gateway_pkg::ADDR_LSB] :
                                      go_cfg ? pick_addr : '0;
                        o_drv_wdata <= go_wr ? wr_req_q[gateway_pkg::DATA_MSB:gateway_pkg::DATA_LSB] :
                                       go_cfg ? pick_data : '0;
                    end
                end
                gateway_pkg::ST_BUSY: begin
                    if (done) begin
                        state_q <= gateway_pkg::ST_IDLE;
                        o_drv_req <= 1'b0;
                        if (cur_host_q && cur_op_q == gateway_pkg::OP_READ) begin
                            rd_result_q <= i_drv_rdata;
                        end
                        if (cur_host_q && cur_op_q == gateway_pkg::OP_WRITE) begin
                            wr_resp_q <= i_drv_rdata;
                        end
                        if (cur_op_q == gateway_pkg::OP_WRITE && i_commit_required) begin
                            o_param_unapplied <= 1'b1;
                        end else if (cur_op_q == gateway_pkg::OP_COMMIT_RAM
                                     || cur_op_q == gateway_pkg::OP_COMMIT_NV) begin
                            o_param_unapplied <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= gateway_pkg::ST_IDLE;
                    o_drv_req <= 1'b0;
                end
            endcase
        end
    end

endmodule : fieldbus_drive_register_gateway

// File: hdl/gateway_pkg.sv
package gateway_pkg;

    // =====================================================================
    // Object indices and subindices
    // =====================================================================
    localparam logic [15:0] IDX_RD_REQ = 16'h2040;
    localparam logic [15:0] IDX_WR_REQ = 16'h2050;
    localparam logic [15:0] IDX_COMMIT_RAM = 16'h2060;
    localparam logic [15:0] IDX_COMMIT_NV = 16'h2070;
    localparam logic [15:0] IDX_CFG_WIDE = 16'h2080;
    localparam logic [15:0] IDX_STAT_RAW = 16'h2100;
    localparam logic [15:0] IDX_STAT_FILT = 16'h2101;
    localparam logic [15:0] IDX_RD_RESULT = 16'h2140;
    localparam logic [15:0] IDX_WR_RESP = 16'h2150;
    localparam int NARROW_COUNT = 6;
    localparam logic [NARROW_COUNT-1:0][15:0] IDX_CFG_NARROW = {
        16'h3100, 16'h3000, 16'h20C0, 16'h20B0, 16'h20A0, 16'h2090};
    localparam int CFG_SLOTS = NARROW_COUNT + 2;

    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_VALUE = 8'h01;
    localparam logic [7:0] SUB_LINK = 8'h02;
    localparam logic [7:0] SUB_FILT_VAL = 8'h03;
    localparam logic [7:0] SUB_FILT_TYPE = 8'h04;

    localparam logic [31:0] REQ_ENTRIES = 32'h0000_0001;
    localparam logic [31:0] CFG_ENTRIES = 32'h0000_0002;
    localparam logic [31:0] FILT_ENTRIES = 32'h0000_0004;

    // =====================================================================
    // Field layout and reset values
    // =====================================================================
    // Byte 1 is the least significant byte of the 32-bit object value.
    localparam int ADDR_MSB = 31;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    // The ASCII bytes s, a, v, e in byte order 1 to 4.
    localparam logic [31:0] SAVE_WORD = 32'h6576_6173;
    localparam logic [15:0] LINK_NONE = 16'hFFFF;
    localparam logic [15:0] FILT_SRC_ADDR = 16'h00FC;
    localparam logic [15:0] FILT_VAL_RESET = 16'h0000;
    localparam logic [15:0] FILT_TYPE_ANALOG = 16'h0000;
    localparam logic [15:0] FILT_TYPE_BITMASK = 16'h0001;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // =====================================================================
    // Drive transaction codes, states and timing
    // =====================================================================
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_COMMIT_RAM = 2'h2,
        OP_COMMIT_NV = 2'h3
    } drive_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } xact_state_t;

    localparam int CLK_PERIOD_NS = 100;
    localparam int CYCLE_TIME_NS = 2000000;
    localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;

endpackage : gateway_pkg

// File: hdl/cycle_timer.sv
`timescale 1ns/1ns
module cycle_timer #(
    parameter int unsigned PERIOD = 20000
) (
    input wire logic i_clk_sys,  // System clock.
    input wire logic i_resetn,   // Synchronous reset, active low.
    output logic o_tick          // One-cycle pulse once per period.
);

    localparam int unsigned W = $clog2(PERIOD) + 1;
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            count_q <= '0;
            o_tick <= 1'b0;
        end else if (count_q == LAST) begin
            count_q <= '0;
            o_tick <= 1'b1;
        end else begin
            count_q <= count_q + W'(1);
            o_tick <= 1'b0;
        end
    end

endmodule : cycle_timer

// File: test/gateway_checker.sv
`timescale 1ns/1ns
module gateway_checker (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_od_wr,
    input wire logic i_od_rd,
    input wire logic [15:0] i_od_index,
    input wire logic [7:0] i_od_sub,
    input wire logic [31:0] i_od_wdata,
    input wire logic o_od_ack,
    input wire logic o_od_err,
    input wire logic [31:0] o_od_rdata,
    input wire logic i_node_preop,
    input wire logic i_drive_running,
    input wire logic o_drv_req,
    input wire logic [1:0] o_drv_op,
    input wire logic [15:0] o_drv_addr,
    input wire logic [15:0] o_drv_wdata,
    input wire logic i_drv_done,
    input wire logic [15:0] i_drv_rdata
);
    // =====================================================================
    // Last read word handed back by the drive, kept for the result check.
    logic [15:0] rd_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rd_q <= 16'h0000;
        end else if (o_drv_req && i_drv_done && o_drv_op == 2'h0) begin
            rd_q <= i_drv_rdata;
        end
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    property p_ack; (i_od_wr || i_od_rd) |=> o_od_ack; endproperty
    a_ack: assert property (p_ack) else $error("missing ack");
    property p_hold; o_drv_req && !i_drv_done |=>
        o_drv_req && $stable({o_drv_op, o_drv_addr, o_drv_wdata}); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_drop; o_drv_req && i_drv_done |=> !o_drv_req; endproperty
    a_drop: assert property (p_drop) else $error("request stuck");
    property p_rdres; i_od_rd && !i_od_wr && !i_drv_done && i_od_index == 16'h2140 &&
        i_od_sub == 8'h00 |=> o_od_rdata == {16'h0000, rd_q}; endproperty
    a_rdres: assert property (p_rdres) else $error("bad read result");
    property p_ro; i_od_wr && i_od_index == 16'h2100 |=> o_od_err; endproperty
    a_ro: assert property (p_ro) else $error("raw status written");
    property p_lock; i_od_wr && i_od_index == 16'h2090 && i_od_sub == 8'h02 &&
        (!i_node_preop || i_drive_running) |=> o_od_err; endproperty
    a_lock: assert property (p_lock) else $error("link not locked");
    property p_cram; i_od_wr && i_od_index == 16'h2060 && i_od_sub == 8'h00 &&
        i_od_wdata == 32'h6576_6173 |-> ##[2:60] (o_drv_req && o_drv_op == 2'h2); endproperty
    a_cram: assert property (p_cram) else $error("no volatile commit");
    property p_cnv; i_od_wr && i_od_index == 16'h2070 && i_od_sub == 8'h00 &&
        i_od_wdata == 32'h6576_6173 |-> ##[2:60] (o_drv_req && o_drv_op == 2'h3); endproperty
    a_cnv: assert property (p_cnv) else $error("no stored commit");
endmodule : gateway_checker

// File: test/drive_model.sv
`timescale 1ns/1ns
module drive_model (
    input wire logic i_clk_sys,   // System clock.
    input wire logic i_slow,      // Answer after five cycles instead of one.
    input wire logic i_req,       // Transaction request.
    input wire logic [1:0] i_op,  // Transaction code.
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic o_done = 1'h0,
    output logic [15:0] o_rdata = 16'hA5C3
);
    // =====================================================================
    // Drive side; the answer bus toggles whenever it carries nothing.
    logic [2:0] cnt_q = 3'h0;
    wire fire = i_req && !o_done && cnt_q == (i_slow ? 3'h4 : 3'h0);
    always @(posedge i_clk_sys) begin
        cnt_q <= (i_req && !o_done) ? cnt_q + 3'h1 : 3'h0;
        o_done <= fire;
        o_rdata <= fire ? ((i_op == 2'h0) ? ~i_addr : i_wdata) : ~o_rdata;
    end
endmodule : drive_model

// File: test/tb_top.sv
`timescale 1ns/1ns
`define CHK(x, y) begin compares++; if ((x) !== (y)) begin miscompares++; \
    $display("BAD %0t %h %h", $time, x, y); end end
module tb_top;
    logic i_clk_sys = 1'h0, i_resetn = 1'h0, i_od_wr = 1'h0, i_od_rd = 1'h0, slow = 1'h0;
    logic i_node_preop = 1'h1, i_drive_running = 1'h0, i_commit_required = 1'h0;
    logic [15:0] i_od_index = 16'h0000, i_drv_status = 16'h0000, a, d;
    logic [7:0] i_od_sub = 8'h00;
    logic [31:0] i_od_wdata = 32'h0000_0000, o_od_rdata;
    logic i_drv_done, o_od_ack, o_od_err, o_drv_req, o_param_unapplied;
    logic [15:0] i_drv_rdata, o_drv_addr, o_drv_wdata, o_status_raw, o_status_filt;
    logic [1:0] o_drv_op;
    int compares = 0, miscompares = 0;
    logic pend = 1'h0;
    fieldbus_drive_register_gateway #(.CYCLE_CLKS(8)) i_dut (.*);
    drive_model i_drv (.i_clk_sys, .i_slow(slow), .i_req(o_drv_req), .i_op(o_drv_op),
        .i_addr(o_drv_addr), .i_wdata(o_drv_wdata), .o_done(i_drv_done), .o_rdata(i_drv_rdata));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    // =====================================================================
    // Object accesses and drive transaction waits.
    task automatic finish_test;
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] wd, input logic err, input logic [31:0] rd);
        @(negedge i_clk_sys);
        {i_od_wr, i_od_rd, i_od_index, i_od_sub, i_od_wdata} = {wr, !wr, idx, sub, wd};
        @(negedge i_clk_sys);
        {i_od_wr, i_od_rd} = 2'h0;
        `CHK({o_od_ack, o_od_err}, {1'h1, err})
        if (!wr) `CHK(o_od_rdata, rd)
    endtask : acc
    task automatic wait_req(input logic [1:0] op, input logic [15:0] ad, wd);
        int n = 0;
        while (!(o_drv_req === 1'h1 && o_drv_op === op) && n < 80) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK({o_drv_addr, o_drv_wdata}, {ad, wd})
        while (o_drv_req !== 1'h0 && n < 80) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 80) begin
            miscompares++;
            finish_test();
        end
    endtask : wait_req
    initial begin
        void'($urandom(89239));
        repeat (20) @(negedge i_clk_sys);
        i_resetn = 1'h1;
        acc(1'h0, 16'h2080, 8'h00, 32'h0, 1'h0, 32'h2);
        acc(1'h0, 16'h2080, 8'h02, 32'h0, 1'h0, 32'hFFFF_FFFF);
        acc(1'h0, 16'h20C0, 8'h02, 32'h0, 1'h0, 32'hFFFF);
        acc(1'h0, 16'h2101, 8'h00, 32'h0, 1'h0, 32'h4);
        acc(1'h0, 16'h2101, 8'h02, 32'h0, 1'h0, 32'hFC);
        acc(1'h0, 16'h2101, 8'h03, 32'h0, 1'h0, 32'h0);
        acc(1'h0, 16'h2101, 8'h04, 32'h0, 1'h0, 32'h1);
        acc(1'h1, 16'h2100, 8'h00, 32'h1, 1'h1, 32'h0);
        acc(1'h0, 16'h1234, 8'h00, 32'h0, 1'h1, 32'h0);
        repeat (6) begin
            a = 16'($urandom);
            d = 16'($urandom);
            slow = 1'($urandom);
            i_commit_required = 1'($urandom);
            i_drv_status = 16'($urandom);
            acc(1'h1, 16'h2040, 8'h01, {a, 16'h0000}, 1'h0, 32'h0);
            wait_req(2'h0, a, 16'h0000);
            acc(1'h0, 16'h2140, 8'h00, 32'h0, 1'h0, {16'h0000, ~a});
            acc(1'h1, 16'h2050, 8'h01, {a, d}, 1'h0, 32'h0);
            wait_req(2'h1, a, d);
            pend = pend | i_commit_required;
            acc(1'h0, 16'h2150, 8'h00, 32'h0, 1'h0, {16'h0000, d});
        end
        `CHK(o_param_unapplied, pend)
        acc(1'h1, 16'h2060, 8'h00, 32'h6576_6173, 1'h0, 32'h0);
        wait_req(2'h2, 16'h0000, 16'h0000);
        `CHK(o_param_unapplied, 1'h0)
        acc(1'h1, 16'h2070, 8'h00, 32'h6576_6173, 1'h0, 32'h0);
        wait_req(2'h3, 16'h0000, 16'h0000);
        i_node_preop = 1'h0;
        acc(1'h1, 16'h2090, 8'h02, 32'h1234, 1'h1, 32'h0);
        i_node_preop = 1'h1;
        i_drive_running = 1'h1;
        acc(1'h1, 16'h2101, 8'h04, 32'h0, 1'h1, 32'h0);
        i_drive_running = 1'h0;
        acc(1'h1, 16'h2090, 8'h02, {16'h0000, a}, 1'h0, 32'h0);
        acc(1'h0, 16'h2090, 8'h02, 32'h0, 1'h0, {16'h0000, a});
        i_commit_required = 1'h1;
        acc(1'h1, 16'h2090, 8'h01, {16'h0000, d}, 1'h0, 32'h0);
        wait_req(2'h1, a, d);
        `CHK(o_param_unapplied, 1'h1)
        i_drv_status = {1'h0, ~i_drv_status[14:0]};
        a = i_drv_status;
        repeat (10) @(negedge i_clk_sys);
        `CHK(o_status_raw, i_drv_status)
        `CHK(o_status_filt, i_drv_status)
        acc(1'h1, 16'h2101, 8'h03, 32'h0000_0100, 1'h0, 32'h0);
        i_drv_status = a ^ 16'h0100;
        repeat (10) @(negedge i_clk_sys);
        `CHK(o_status_filt, a)
        acc(1'h1, 16'h2101, 8'h04, 32'h0, 1'h0, 32'h0);
        i_drv_status = a + 16'h0100;
        repeat (10) @(negedge i_clk_sys);
        `CHK(o_status_filt, a)
        i_drv_status = a + 16'h0101;
        repeat (10) @(negedge i_clk_sys);
        `CHK({o_status_raw, o_status_filt}, {2{i_drv_status}})
        finish_test();
    end
endmodule : tb_top
bind fieldbus_drive_register_gateway gateway_checker i_chk (.*);
